// ### rtl/adcsc_pkg.sv
/*
 * Shared constants and types for the converter step configuration bank:
 * register offsets, field layouts, reset values and mux encodings.
 * Assumes a 32-bit APB with byte addresses and word-aligned registers.
 */
package adcsc_pkg;

   // register byte offsets within the converter block
   localparam logic [11:0] IDLE_HIGH_OFS  = 12'h0A4;
   localparam logic [11:0] IDLE_LOW_OFS   = 12'h0A8;
   localparam logic [11:0] MASKED_IRQ_OFS = 12'h0AC;
   localparam logic [11:0] STEP_HIGH_BASE = 12'h200;
   localparam logic [11:0] STEP_LOW_BASE  = 12'h240;

   // documented number of conversion steps and word widths
   localparam int STEP_COUNT  = 16;
   localparam int WORD_W      = 16;
   localparam int LOW_USED_W  = 14;
   localparam int IRQ_W       = 5;

   // values after reset
   localparam logic [15:0] HIGH_RESET = 16'h0000;
   localparam logic [13:0] LOW_RESET  = 14'h0000;
   localparam logic [8:0]  SETTLE_RESET = 9'h000;

   // masked status bit positions
   localparam int IRQ_OVERFLOW_BIT = 0;
   localparam int IRQ_LEVEL_BIT    = 1;
   localparam int IRQ_DONE_BIT     = 2;
   localparam int IRQ_PEN_BIT      = 3;
   localparam int IRQ_BROWNOUT_BIT = 4;

   // negative input routing
   typedef enum logic {
      NEG_IN_REF,
      NEG_IN_GROUND
   } adcscNegIn_type;

   // positive reference routing, in encoding order
   typedef enum logic [1:0] {
      POS_REF_PIN,
      POS_REF_ANALOG_IN_ZERO,
      POS_REF_ANALOG_IN_TWO,
      POS_REF_ANALOG_IN_EIGHT
   } adcscPosRef_type;

   // negative reference routing, in encoding order
   typedef enum logic [1:0] {
      NEG_REF_PIN,
      NEG_REF_ANALOG_IN_ONE,
      NEG_REF_ANALOG_IN_THREE,
      NEG_REF_ANALOG_IN_NINE
   } adcscNegRef_type;

   // high word: settle [15:7], pos input [6:3], neg input [2], pos ref [1:0]
   typedef struct packed {
      logic [8:0]      settle;
      logic [3:0]      posInSel;
      adcscNegIn_type  negInSel;
      adcscPosRef_type posRefSel;
   } adcscHigh_type;

   // low word used bits: bias switches [13:2], neg ref [1:0]
   typedef struct packed {
      logic [11:0]     biasSwitches;
      adcscNegRef_type negRefSel;
   } adcscLow_type;

   // one 30-bit conversion step description
   typedef struct packed {
      adcscHigh_type hi;
      adcscLow_type  lo;
   } adcscStep_type;

endpackage : adcsc_pkg

// ### rtl/adcsc_step_apply.sv
/*
 * Applies either the current step's bank entry pair or the idle words to
 * the analog muxes, and holds off the pen interrupt after idle entry.
 * Assumes the sequencer drives seqIdle and stepIndex on ref_clk and that
 * adcClkEn is a one-cycle pulse per converter clock.
 */
`timescale 1ns/100ps
module adcsc_step_apply #(
   parameter int STEPS = adcsc_pkg::STEP_COUNT
) (
   input  wire logic                                 ref_clk,
   input  wire logic                                 rst_n,
   input  wire logic                                 seqIdle,
   input  wire logic [3:0]                           stepIndex,
   input  wire logic                                 adcClkEn,
   input  wire logic                                 penRaw,
   input  wire adcsc_pkg::adcscHigh_type [STEPS-1:0] stepHigh,
   input  wire adcsc_pkg::adcscLow_type  [STEPS-1:0] stepLow,
   input  wire adcsc_pkg::adcscStep_type             idleCfg,
   output adcsc_pkg::adcscStep_type                  activeCfg,
   output logic                                      penIrq
);
   import adcsc_pkg::*;

   adcscStep_type next_activeCfg;
   logic [8:0]    settleCount;
   logic [8:0]    next_settleCount;
   logic          wasIdle;
   logic          next_wasIdle;
   logic          next_penIrq;

   // route the step pair while sequencing, the idle words otherwise
   always_comb begin
      next_activeCfg = idleCfg;
      if (!seqIdle) begin
         if (32'(stepIndex) < STEPS) begin
            next_activeCfg = {stepHigh[stepIndex], stepLow[stepIndex]};
         end else begin
            next_activeCfg = '0;
         end
      end
   end

   // idle settle countdown in converter clocks; pen held off until it ends
   always_comb begin
      next_wasIdle     = seqIdle;
      next_settleCount = settleCount;
      if (seqIdle && !wasIdle) begin
         next_settleCount = idleCfg.hi.settle;
      end else if (seqIdle && adcClkEn && settleCount != 9'h000) begin
         next_settleCount = settleCount - 9'h001;
      end
      // outside idle the step bias decides, so pen passes straight
      next_penIrq = penRaw;
      if (seqIdle) begin
         next_penIrq = penRaw && wasIdle && settleCount == 9'h000;
      end
   end

   // state registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         activeCfg   <= '0;
         settleCount <= SETTLE_RESET;
         wasIdle     <= 1'b0;
         penIrq      <= 1'b0;
      end else begin
         activeCfg   <= next_activeCfg;
         settleCount <= next_settleCount;
         wasIdle     <= next_wasIdle;
         penIrq      <= next_penIrq;
      end
   end

   AST_IDLE_APPLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seqIdle |=> activeCfg == $past(idleCfg))
      else $error("idle words not applied while idle");

   AST_STEP_APPLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!seqIdle && stepIndex == 4'h1) |=>
         activeCfg == {$past(stepHigh[1]), $past(stepLow[1])})
      else $error("step pair not applied during sequence");

   AST_PEN_HOLDOFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (seqIdle && !wasIdle && idleCfg.hi.settle != 9'h000)
         |=> !penIrq ##1 !penIrq)
      else $error("pen raised before idle settle elapsed");

endmodule : adcsc_step_apply

// ### rtl/adcsc_ctrl_bank.sv
/*
 * Converter step configuration bank with idle words and masked status,
 * reached over APB.
 * Assumes the APB master keeps psel/pwrite/paddr/pwdata stable over both
 * phases and that latched interrupt status and mask come from outside.
 */
`timescale 1ns/100ps
module adcsc_ctrl_bank #(
   parameter int STEPS = adcsc_pkg::STEP_COUNT
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     seqIdle,
   input  wire logic [3:0]               stepIndex,
   input  wire logic                     adcClkEn,
   input  wire logic                     penRaw,
   input  wire logic [4:0]               irqLatched,
   input  wire logic [4:0]               irqEnable,
   output adcsc_pkg::adcscStep_type      activeCfg,
   output logic                          penIrq
);
   import adcsc_pkg::*;

   // refuse step counts the 4-bit index and address map cannot serve
   if (STEPS < 1 || STEPS > STEP_COUNT) begin : gBadSteps
      $error("STEPS must lie between 1 and 16");
   end

   adcscHigh_type [STEPS-1:0] stepHigh;
   adcscLow_type  [STEPS-1:0] stepLow;
   adcscHigh_type             idleHigh;
   adcscHigh_type             next_idleHigh;
   adcscLow_type              idleLow;
   adcscLow_type              next_idleLow;
   logic [31:0]               next_prdata;
   logic                      next_pslverr;
   logic                      setupPhase;
   logic                      apbWrite;
   logic                      hitHigh;
   logic                      hitLow;
   logic                      hitIdleHigh;
   logic                      hitIdleLow;
   logic                      hitMasked;
   logic [3:0]                bankIdx;
   logic [4:0]                maskedIrq;

   // address decode; bank entries are one aligned word each
   always_comb begin
      setupPhase  = psel && !penable;
      apbWrite    = psel && penable && pwrite;
      bankIdx     = paddr[5:2];
      hitHigh     = paddr[11:6] == STEP_HIGH_BASE[11:6]
                    && 32'(bankIdx) < STEPS && paddr[1:0] == 2'b00;
      hitLow      = paddr[11:6] == STEP_LOW_BASE[11:6]
                    && 32'(bankIdx) < STEPS && paddr[1:0] == 2'b00;
      hitIdleHigh = paddr == IDLE_HIGH_OFS;
      hitIdleLow  = paddr == IDLE_LOW_OFS;
      hitMasked   = paddr == MASKED_IRQ_OFS;
      maskedIrq   = irqLatched & irqEnable;
   end

   // one high and one low entry per step, paired by index
   for (genvar i = 0; i < STEPS; i++) begin : gEntry
      adcscHigh_type next_high;
      adcscLow_type  next_low;

      always_comb begin
         next_high = stepHigh[i];
         next_low  = stepLow[i];
         if (apbWrite && hitHigh && 32'(bankIdx) == i) begin
            next_high = adcscHigh_type'(pwdata[WORD_W-1:0]);
         end
         // only 14 bits are stored, so the top two cannot read back
         if (apbWrite && hitLow && 32'(bankIdx) == i) begin
            next_low = adcscLow_type'(pwdata[LOW_USED_W-1:0]);
         end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            stepHigh[i] <= adcscHigh_type'(HIGH_RESET);
            stepLow[i]  <= adcscLow_type'(LOW_RESET);
         end else begin
            stepHigh[i] <= next_high;
            stepLow[i]  <= next_low;
         end
      end
   end

   // idle words; bits above each used width are not stored, low word bits 11:9 are
   always_comb begin
      next_idleHigh = idleHigh;
      next_idleLow  = idleLow;
      if (apbWrite && hitIdleHigh) begin
         next_idleHigh = adcscHigh_type'(pwdata[WORD_W-1:0]);
      end
      // word bits 11:9 are stored as given; software keeps them zero
      if (apbWrite && hitIdleLow) begin
         next_idleLow = adcscLow_type'(pwdata[LOW_USED_W-1:0]);
      end
   end

   // read data is captured in the setup phase and stands for the access
   always_comb begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (setupPhase) begin
         next_prdata  = 32'h0000_0000;
         next_pslverr = 1'b0;
         if (hitHigh) begin
            next_prdata[WORD_W-1:0] = stepHigh[bankIdx];
         end else if (hitLow) begin
            next_prdata[LOW_USED_W-1:0] = stepLow[bankIdx];
         end else if (hitIdleHigh) begin
            next_prdata[WORD_W-1:0] = idleHigh;
         end else if (hitIdleLow) begin
            next_prdata[LOW_USED_W-1:0] = idleLow;
         end else if (hitMasked) begin
            next_prdata[IRQ_W-1:0] = maskedIrq;
            next_pslverr = pwrite; // status is read only
         end else begin
            next_pslverr = 1'b1; // unmapped address
         end
      end
   end

   // register stage for idle words and the read path
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idleHigh <= adcscHigh_type'(HIGH_RESET);
         idleLow  <= adcscLow_type'(LOW_RESET);
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
      end else begin
         idleHigh <= next_idleHigh;
         idleLow  <= next_idleLow;
         prdata   <= next_prdata;
         pslverr  <= next_pslverr;
      end
   end

   // every access completes with no wait state
   assign pready = 1'b1;

   adcsc_step_apply #(
      .STEPS (STEPS)
   ) uApply (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .seqIdle   (seqIdle),
      .stepIndex (stepIndex),
      .adcClkEn  (adcClkEn),
      .penRaw    (penRaw),
      .stepHigh  (stepHigh),
      .stepLow   (stepLow),
      .idleCfg   ({idleHigh, idleLow}),
      .activeCfg (activeCfg),
      .penIrq    (penIrq)
   );

   AST_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (apbWrite && hitHigh) |=>
         stepHigh[$past(bankIdx)] == $past(pwdata[15:0]))
      else $error("high bank entry did not take written value");

   AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (apbWrite && hitLow) |=>
         stepLow[$past(bankIdx)] == $past(pwdata[13:0]))
      else $error("low bank entry did not take written value");

   AST_LOW_READ_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (setupPhase && hitLow) |=> prdata[31:14] == 18'h00000)
      else $error("low bank read returned nonzero top bits");

   AST_HIGH_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (setupPhase && hitHigh) |=>
         prdata == {16'h0000, $past(stepHigh[bankIdx])})
      else $error("high bank read mismatch");

   AST_IDLE_LOW_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (setupPhase && hitIdleLow) |=> prdata[31:14] == 18'h00000)
      else $error("idle low reserved bits read nonzero");

   AST_MASKED_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (setupPhase && hitMasked) |=>
         prdata == {27'h0000000, $past(irqLatched & irqEnable)})
      else $error("masked status read mismatch");

   AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (setupPhase && !(hitHigh || hitLow || hitIdleHigh || hitIdleLow
                       || hitMasked)) |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");

   AST_IDLE_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (apbWrite && hitIdleHigh) |=> idleHigh == $past(pwdata[15:0])
         ##1 ($past(seqIdle) ? activeCfg.hi == $past(idleHigh) : 1'b1))
      else $error("idle high write not applied");

endmodule : adcsc_ctrl_bank

// ### testbench/adcsc_far_model.sv
/*
 Far-side model: the sequencer and analog front end that face the bank.
 Assumes the bench picks idle, step and pen level; clock and reset shared.
*/
`timescale 1ns/100ps
module adcsc_far_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       idleReq,
   input  wire logic [3:0] stepReq,
   input  wire logic       penLevel,
   output logic            seqIdle,
   output logic [3:0]      stepIndex,
   output logic            adcClkEn,
   output logic            penRaw
);
   logic [1:0] div;
   // sequencer state and pen comparator follow the bench directly
   assign seqIdle   = idleReq;
   assign stepIndex = stepReq;
   assign penRaw    = penLevel;
   // converter clock is a quarter of ref_clk, so settle counts run slower
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 2'h0;
         adcClkEn <= 1'b0;
      end else begin
         div <= div + 2'h1;
         adcClkEn <= (div == 2'h3);
      end
   end
endmodule : adcsc_far_model

// ### testbench/adcsc_ctrl_bank_tb.sv
/*
 Self-checking bench for the step configuration bank: APB tasks, bank,
 idle words, masked status, step selection and pen hold-off.
 Assumes the bank answers with no wait states, as its notes state.
*/
`timescale 1ns/100ps
module adcsc_ctrl_bank_tb;
   import adcsc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n, psel, penable, pwrite, idleReq, penLevel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic pready, pslverr, seqIdle, adcClkEn, penRaw, penIrq, e;
   logic [3:0] stepIndex, stepReq;
   logic [4:0] irqLatched, irqEnable;
   logic [15:0] hv [16];
   logic [15:0] lv [16];
   adcscStep_type activeCfg;
   int errors = 0;
   int n_tests = 0;
   int np;

   adcsc_ctrl_bank i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seqIdle(seqIdle), .stepIndex(stepIndex), .adcClkEn(adcClkEn),
      .penRaw(penRaw), .irqLatched(irqLatched), .irqEnable(irqEnable),
      .activeCfg(activeCfg), .penIrq(penIrq));
   adcsc_far_model i_far (.ref_clk(ref_clk), .rst_n(rst_n),
      .idleReq(idleReq), .stepReq(stepReq), .penLevel(penLevel),
      .seqIdle(seqIdle), .stepIndex(stepIndex), .adcClkEn(adcClkEn),
      .penRaw(penRaw));

   // 20 MHz system clock
   always #25 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one APB transfer; request held until the edge where pready is high
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : xfer

   task automatic settle2();
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      @(posedge ref_clk);
   endtask : settle2

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   // watchdog: the whole sequence needs well under 10000 cycles
   initial begin
      #500000;
      errors++;
      stop_test();
   end

   initial begin
      {psel, penable, pwrite, idleReq, penLevel} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      stepReq = 4'h0;
      irqLatched = 5'h00;
      irqEnable = 5'h00;
      rst_n = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      xfer(0, IDLE_HIGH_OFS, 0, d, e); chk(d, 32'h0);
      xfer(0, IDLE_LOW_OFS, 0, d, e); chk(d, 32'h0);
      xfer(0, MASKED_IRQ_OFS, 0, d, e); chk(d, 32'h0);
      $display("test reset values done");
      // fill every entry first, then read back, so aliasing shows
      for (int i = 0; i < STEP_COUNT; i++) begin
         hv[i] = 16'hA5C3 ^ (16'h1111 * i[15:0]);
         lv[i] = 16'hF00F ^ (16'h0F0F * i[15:0]);
         xfer(1, STEP_HIGH_BASE + 12'(4 * i), {16'hDEAD, hv[i]}, d, e);
         xfer(1, STEP_LOW_BASE + 12'(4 * i), {16'hBEEF, lv[i]}, d, e);
      end
      for (int i = 0; i < STEP_COUNT; i++) begin
         xfer(0, STEP_HIGH_BASE + 12'(4 * i), 0, d, e);
         chk(d, {16'h0, hv[i]});
         xfer(0, STEP_LOW_BASE + 12'(4 * i), 0, d, e);
         chk(d, {18'h0, lv[i][13:0]});
      end
      $display("test bank access done");
      // each step selects its own pair while sequencing
      for (int i = 0; i < STEP_COUNT; i++) begin
         stepReq <= 4'(i);
         settle2();
         chk(32'(activeCfg), {2'h0, hv[i], lv[i][13:0]});
         chk(32'(activeCfg.hi.settle), 32'(hv[i][15:7]));
         chk(32'(activeCfg.lo.biasSwitches), 32'(lv[i][13:2]));
      end
      $display("test step apply done");
      xfer(1, IDLE_HIGH_OFS, 32'hFFFF_FFFF, d, e);
      xfer(0, IDLE_HIGH_OFS, 0, d, e); chk(d, 32'h0000_FFFF);
      xfer(1, IDLE_LOW_OFS, 32'h0000_31FD, d, e);
      xfer(0, IDLE_LOW_OFS, 0, d, e); chk(d, 32'h0000_31FD);
      // every reference routing code, both negative inputs and positive inputs 9 to 12 while idle
      idleReq <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         xfer(1, IDLE_HIGH_OFS, {25'h0, 4'(k + 9), k[0], k[1:0]}, d, e);
         // bias pattern keeps word bits 11:9 clear, as software must
         xfer(1, IDLE_LOW_OFS, {18'h0, 12'hC3C, k[1:0]}, d, e);
         settle2();
         chk(32'(activeCfg.hi.posInSel), 32'(k + 9));
         chk(32'(activeCfg.hi.negInSel), 32'(k[0]));
         chk(32'(activeCfg.hi.posRefSel), 32'(k));
         chk(32'(activeCfg.lo.negRefSel), 32'(k));
         chk(32'(activeCfg.lo.biasSwitches), 32'hC3C);
      end
      $display("test idle routing done");
      for (int b = 0; b < IRQ_W; b++) begin
         irqLatched <= 5'h1F;
         irqEnable <= 5'(1 << b);
         xfer(0, MASKED_IRQ_OFS, 0, d, e); chk(d, 32'(1 << b));
         irqLatched <= 5'(1 << b);
         irqEnable <= ~5'(1 << b);
         xfer(0, MASKED_IRQ_OFS, 0, d, e); chk(d, 32'h0);
      end
      xfer(1, MASKED_IRQ_OFS, 32'hFFFF_FFFF, d, e);
      chk(32'(e), 32'h1);
      xfer(0, 12'h0B4, 0, d, e); chk({d[30:0], e}, 32'h1);
      $display("test masked status done");
      // pen must stay quiet for the idle settle count of converter clocks
      xfer(1, IDLE_HIGH_OFS, 32'h0000_0180, d, e);
      idleReq <= 1'b0;
      penLevel <= 1'b0;
      repeat (3) @(posedge ref_clk);
      idleReq <= 1'b1;
      penLevel <= 1'b1;
      // wait only for the idle-entry edge: every converter pulse after the
      // load counts down, so pulses are counted from the very next cycle
      repeat (1) @(posedge ref_clk);
      np = 0;
      while (np < 3) begin
         @(negedge ref_clk);
         chk(32'(penIrq), 32'h0);
         if (adcClkEn) np++;
      end
      np = 0;
      while (penIrq !== 1'b1 && np < 3) begin
         @(negedge ref_clk);
         np++;
      end
      chk(32'(penIrq), 32'h1);
      $display("test pen hold-off done");
      stop_test();
   end
endmodule : adcsc_ctrl_bank_tb
